// ==== adc_seq_ctrl.sv ====
// Converter control top: APB registers, interrupt and crossings.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module adc_seq_ctrl (
  input  wire logic                     CORE_CLK,
  input  wire logic                     RST,
  input  wire logic                     CONV_CLK,
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [7:0]               PADDR,
  input  wire logic [31:0]              PWDATA,
  output logic      [31:0]              PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  output logic                          IRQ,
  input  wire logic                     ANA_DONE,
  input  wire logic [11:0]              ANA_RESULT,
  output logic                          ANA_POWER_DOWN,
  output logic                          ANA_CAL_START,
  output logic                          ANA_CAL_RESET,
  output logic                          ANA_START,
  output logic [4:0]                    ANA_CHANNEL
);
  import adc_ctrl_pkg::*;

  conv_link_if                          link ();

  logic                                 acc_wait;
  logic                                 wr_fire;
  logic                                 mapped;
  logic [31:0]                          rd_mux;
  logic                                 wr_status;
  logic                                 wr_mask;
  logic                                 wr_ctl;
  logic                                 converter_on;
  logic                                 calibration_start;
  logic                                 align_left;
  logic [31:0]                          sequence_reg_first;
  logic [31:0]                          sequence_reg_second;
  logic [31:0]                          sequence_reg_third;
  logic [FLAG_COUNT-1:0]                status;
  logic [FLAG_COUNT-1:0]                mask;
  logic [DATA_WIDTH-1:0]                data;
  logic                                 cal_tgl;
  logic                                 crst_tgl;
  logic                                 start_tgl;
  logic                                 start_cal;
  logic [1:0]                           back1;
  logic [1:0]                           back2;
  logic [1:0]                           back3;
  logic                                 cal_done_pulse;
  logic                                 conv_done_pulse;

  // ************************************************************
  // APB slave.
  // ************************************************************
  // One wait state: data is registered, writes land on the last edge.
  assign acc_wait  = PSEL & PENABLE & ~PREADY;
  assign wr_fire   = PSEL & PENABLE & PREADY & PWRITE;
  assign wr_status = wr_fire && PADDR == STATUS_OFFSET;
  assign wr_mask   = wr_fire && PADDR == MASK_OFFSET;
  assign wr_ctl    = wr_fire && PADDR == CONTROL_SECOND_OFF;

  // Read decode; control pulse bits read back as zero.
  always_comb begin
    mapped = 1'b1;
    rd_mux = REG_RESET;
    case (PADDR)
      STATUS_OFFSET:      rd_mux[FLAG_COUNT-1:0] = status;
      MASK_OFFSET:        rd_mux[FLAG_COUNT-1:0] = mask;
      CONTROL_SECOND_OFF: begin
        rd_mux[CTL_ON_BIT]         = converter_on;
        rd_mux[CTL_CAL_START_BIT]  = calibration_start;
        rd_mux[CTL_ALIGN_LEFT_BIT] = align_left;
      end
      SEQ_FIRST_OFFSET:   rd_mux = sequence_reg_first;
      SEQ_SECOND_OFFSET:  rd_mux = sequence_reg_second;
      SEQ_THIRD_OFFSET:   rd_mux = sequence_reg_third;
      DATA_OFFSET:        rd_mux[DATA_WIDTH-1:0] = data;
      default:            mapped = 1'b0;
    endcase
  end

  // Unmapped addresses answer with an error and zero data.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= REG_RESET;
    end else begin
      PREADY  <= acc_wait;
      PSLVERR <= acc_wait & ~mapped;
      PRDATA  <= (acc_wait & ~PWRITE) ? rd_mux : REG_RESET;
    end
  end

  // ************************************************************
  // Control and sequence registers.
  // ************************************************************
  // Sequence registers keep only their defined fields.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sequence_reg_first  <= REG_RESET;
      sequence_reg_second <= REG_RESET;
      sequence_reg_third  <= REG_RESET;
      converter_on        <= 1'b0;
      align_left          <= 1'b0;
    end else if (wr_fire) begin
      if (PADDR == SEQ_FIRST_OFFSET) begin
        sequence_reg_first <= PWDATA & 32'h00ff_ffff;
      end
      if (PADDR == SEQ_SECOND_OFFSET) begin
        sequence_reg_second <= PWDATA & 32'h3fff_ffff;
      end
      if (PADDR == SEQ_THIRD_OFFSET) begin
        sequence_reg_third <= PWDATA & 32'h3fff_ffff;
      end
      if (wr_ctl) begin
        converter_on <= PWDATA[CTL_ON_BIT];
        align_left   <= PWDATA[CTL_ALIGN_LEFT_BIT];
      end
    end
  end

  // A new run is taken only when idle or in the finishing cycle.
  // A start in the same write that switches off is refused, so no run
  // can slip across before the far side sees the power-off.
  assign start_cal = wr_ctl & PWDATA[CTL_CAL_START_BIT] & converter_on
                   & PWDATA[CTL_ON_BIT]
                   & (~calibration_start | cal_done_pulse);

  // Start bit stays up for the run; switching off abandons it.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      calibration_start <= 1'b0;
    end else if (wr_ctl && !PWDATA[CTL_ON_BIT]) begin
      calibration_start <= 1'b0;
    end else if (start_cal) begin
      calibration_start <= 1'b1;
    end else if (cal_done_pulse) begin
      calibration_start <= 1'b0;
    end
  end

  // Events travel as toggles; conversion starts are dropped during calibration.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cal_tgl   <= 1'b0;
      crst_tgl  <= 1'b0;
      start_tgl <= 1'b0;
    end else begin
      cal_tgl   <= cal_tgl ^ start_cal;
      crst_tgl  <= crst_tgl ^ (wr_ctl & PWDATA[CTL_CAL_RESET_BIT]
                   & converter_on);
      start_tgl <= start_tgl ^ (wr_ctl & PWDATA[CTL_SOFT_START_BIT]
                   & converter_on & ~calibration_start);
    end
  end

  // ************************************************************
  // Link to the converter clock side.
  // ************************************************************
  // Levels and toggles go out raw; the far side synchronises each one but align_left, which is latched on a start.
  // Sequence fields are quasi-static and latched there only on a start.
  assign link.rst_core       = RST;
  assign link.conv_on        = converter_on;
  assign link.cal_start_tgl  = cal_tgl;
  assign link.cal_reset_tgl  = crst_tgl;
  assign link.conv_start_tgl = start_tgl;
  assign link.align_left     = align_left;
  assign link.seq_len = sequence_reg_first[SEQ_LEN_LSB +: SEQ_LEN_WIDTH];

  // Slots 0-5 from the third register, 6-11 second, 12-15 first.
  always_comb begin
    for (int i = 0; i < SEQ_DEPTH; i++) begin
      if (i < SEQ_SLOTS_PER_REG) begin
        link.seq_chan[i*CHANNEL_WIDTH +: CHANNEL_WIDTH] =
          sequence_reg_third[i*CHANNEL_WIDTH +: CHANNEL_WIDTH];
      end else if (i < 2*SEQ_SLOTS_PER_REG) begin
        link.seq_chan[i*CHANNEL_WIDTH +: CHANNEL_WIDTH] =
          sequence_reg_second[(i-6)*CHANNEL_WIDTH +: CHANNEL_WIDTH];
      end else begin
        link.seq_chan[i*CHANNEL_WIDTH +: CHANNEL_WIDTH] =
          sequence_reg_first[(i-12)*CHANNEL_WIDTH +: CHANNEL_WIDTH];
      end
    end
  end

  adc_conv_domain conv_side (
    .conv_clk       (CONV_CLK),
    .link           (link),
    .ana_done       (ANA_DONE),
    .ana_result     (ANA_RESULT),
    .ana_power_down (ANA_POWER_DOWN),
    .ana_cal_start  (ANA_CAL_START),
    .ana_cal_reset  (ANA_CAL_RESET),
    .ana_start      (ANA_START),
    .ana_channel    (ANA_CHANNEL)
  );

  // Completion toggles come back through two stages before use.
  always_ff @(posedge CORE_CLK) begin
    back1 <= {link.conv_done_tgl, link.cal_done_tgl};
    back2 <= back1;
    back3 <= back2;
  end

  assign cal_done_pulse  = ~RST & (back2[0] ^ back3[0]);
  assign conv_done_pulse = ~RST & (back2[1] ^ back3[1]);

  // Result word changes with its toggle and is stable for many cycles after it.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      data <= '0;
    end else if (conv_done_pulse) begin
      data <= link.result;
    end
  end

  // ************************************************************
  // Interrupt.
  // ************************************************************
  // Sticky flags, write one to clear; a new event beats the clear.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      status <= '0;
      mask   <= '0;
    end else begin
      status <= (status & ~({FLAG_COUNT{wr_status}}
                 & PWDATA[FLAG_COUNT-1:0]))
              | {cal_done_pulse, conv_done_pulse};
      if (wr_mask) begin
        mask <= PWDATA[FLAG_COUNT-1:0];
      end
    end
  end

  // Registered level, so the pin comes straight from a flip-flop.
  // It lags the status and mask registers by one cycle.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(status & mask);
    end
  end

  // ************************************************************
  // Checks.
  // ************************************************************
  // Bus handshake, calibration start and interrupt behaviour.
  ready_once_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    acc_wait |=> PREADY ##1 !PREADY)
    else $error("APB answer not a single cycle.");
  err_unmapped_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    acc_wait && !mapped |=> PSLVERR && PRDATA == '0)
    else $error("Unmapped access not refused.");
  cal_set_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    start_cal |=> calibration_start && cal_tgl != $past(cal_tgl))
    else $error("Calibration start not taken.");
  cal_hold_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    calibration_start && !cal_done_pulse && !wr_ctl |=> calibration_start)
    else $error("Calibration start dropped early.");
  cal_clear_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    cal_done_pulse && !start_cal |=> !calibration_start)
    else $error("Calibration start not cleared.");
  cal_flag_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    cal_done_pulse |=> status[FLAG_CAL_DONE])
    else $error("Calibration done not flagged.");
  off_clear_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    wr_ctl && !PWDATA[CTL_ON_BIT] |=> !converter_on && !calibration_start)
    else $error("Switch-off left calibration pending.");
  done_flag_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    conv_done_pulse |=> status[FLAG_CONV_DONE]
      ##1 (IRQ || !$past(mask[FLAG_CONV_DONE])))
    else $error("Conversion done not flagged.");
  irq_follow_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (status & mask) != '0 |=> IRQ)
    else $error("Interrupt not raised.");
  irq_drop_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (status & mask) == '0 |=> !IRQ)
    else $error("Interrupt raised with nothing pending.");
  no_conv_cal_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    calibration_start |=> start_tgl == $past(start_tgl))
    else $error("Conversion started during calibration.");
endmodule

// ==== adc_ctrl_pkg.sv ====
// Shared constants and types of the converter control block.
package adc_ctrl_pkg;

  // ************************************************************
  // Register offsets (byte addresses on the bus).
  // ************************************************************
  localparam logic [7:0] STATUS_OFFSET      = 8'h00;
  localparam logic [7:0] MASK_OFFSET        = 8'h04;
  localparam logic [7:0] CONTROL_SECOND_OFF = 8'h08;
  localparam logic [7:0] SEQ_FIRST_OFFSET   = 8'h2c;
  localparam logic [7:0] SEQ_SECOND_OFFSET  = 8'h30;
  localparam logic [7:0] SEQ_THIRD_OFFSET   = 8'h34;
  localparam logic [7:0] DATA_OFFSET        = 8'h4c;

  // ************************************************************
  // Field positions.
  // ************************************************************
  localparam int FLAG_CONV_DONE     = 0;
  localparam int FLAG_CAL_DONE      = 1;
  localparam int FLAG_COUNT         = 2;
  localparam int CTL_ON_BIT         = 0;
  localparam int CTL_CAL_START_BIT  = 2;
  localparam int CTL_CAL_RESET_BIT  = 3;
  localparam int CTL_ALIGN_LEFT_BIT = 11;
  localparam int CTL_SOFT_START_BIT = 22;
  localparam int SEQ_LEN_LSB        = 20;
  localparam int SEQ_LEN_WIDTH      = 4;
  localparam int SEQ_SLOTS_PER_REG  = 6;

  // ************************************************************
  // Sizes, reset values and timing.
  // ************************************************************
  localparam int CHANNEL_WIDTH = 5;
  localparam int SEQ_DEPTH     = 16;
  localparam int RESULT_WIDTH  = 12;
  localparam int DATA_WIDTH    = 16;
  localparam logic [CHANNEL_WIDTH-1:0] CHANNEL_LAST = 5'h12;
  localparam logic [31:0] REG_RESET     = 32'h0000_0000;
  localparam int SETTLE_CONV_CYCLES     = 14;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CAL  = 2'b01,
    ST_CONV = 2'b10
  } conv_state_type;

endpackage

// ==== conv_link_if.sv ====
// Signals passed between the bus side and the converter clock side.
`timescale 1ns/1ps
interface conv_link_if;
  import adc_ctrl_pkg::*;
  logic                                   rst_core;
  logic                                   conv_on;
  logic                                   cal_start_tgl;
  logic                                   cal_reset_tgl;
  logic                                   conv_start_tgl;
  logic                                   align_left;
  logic [SEQ_LEN_WIDTH-1:0]               seq_len;
  logic [SEQ_DEPTH*CHANNEL_WIDTH-1:0]     seq_chan;
  logic                                   cal_done_tgl;
  logic                                   conv_done_tgl;
  logic [DATA_WIDTH-1:0]                  result;

  modport core (output rst_core, conv_on, cal_start_tgl, cal_reset_tgl,
                conv_start_tgl, align_left, seq_len, seq_chan,
                input cal_done_tgl, conv_done_tgl, result);
  modport conv (input rst_core, conv_on, cal_start_tgl, cal_reset_tgl,
                conv_start_tgl, align_left, seq_len, seq_chan,
                output cal_done_tgl, conv_done_tgl, result);
endinterface

// ==== adc_conv_domain.sv ====
// Converter clock side: calibration, sequencing and result shaping.
`timescale 1ns/1ps
module adc_conv_domain (
  input  wire logic                     conv_clk,
  conv_link_if.conv                     link,
  input  wire logic                     ana_done,
  input  wire logic [11:0]              ana_result,
  output logic                          ana_power_down,
  output logic                          ana_cal_start,
  output logic                          ana_cal_reset,
  output logic                          ana_start,
  output logic [4:0]                    ana_channel
);
  import adc_ctrl_pkg::*;

  logic                                 rst_s1;
  logic                                 rst_s2;
  logic                                 on_s1;
  logic                                 on_s2;
  logic                                 conv_rst;
  logic [2:0]                           tg1;
  logic [2:0]                           tg2;
  logic [2:0]                           tg3;
  logic [2:0]                           ev;
  conv_state_type                       state;
  logic [SEQ_LEN_WIDTH-1:0]             idx;
  logic [SEQ_LEN_WIDTH-1:0]             len;
  logic [SEQ_DEPTH*CHANNEL_WIDTH-1:0]   chans;
  logic                                 left;
  logic [RESULT_WIDTH-1:0]              factor;
  logic [RESULT_WIDTH-1:0]              corrected;
  logic [CHANNEL_WIDTH-1:0]             next_channel;

  // ************************************************************
  // Crossings from the bus side.
  // ************************************************************
  // Level and toggle synchronisers; only stage two, and stage three for toggles, feeds logic.
  always_ff @(posedge conv_clk) begin
    rst_s1 <= link.rst_core;
    rst_s2 <= rst_s1;
    on_s1  <= link.conv_on;
    on_s2  <= on_s1;
    tg1    <= {link.conv_start_tgl, link.cal_reset_tgl, link.cal_start_tgl};
    tg2    <= tg1;
    tg3    <= tg2;
  end

  // Converter logic sits in reset while switched off.
  always_ff @(posedge conv_clk) begin
    conv_rst       <= rst_s2 | ~on_s2;
    ana_power_down <= rst_s2 | ~on_s2;
  end

  // Events are dropped while held in reset, so no stale work starts.
  assign ev = (tg2 ^ tg3) & {3{~conv_rst}};

  // ************************************************************
  // Sequencer.
  // ************************************************************
  // Channel of the following slot; codes past the last fall back to input 0.
  assign next_channel = chans[(idx+1'b1)*CHANNEL_WIDTH +: CHANNEL_WIDTH];

  // Calibration and routine conversions share the analog core.
  always_ff @(posedge conv_clk) begin
    ana_start     <= 1'b0;
    ana_cal_start <= 1'b0;
    ana_cal_reset <= ev[1];
    if (conv_rst) begin
      state       <= ST_IDLE;
      idx         <= '0;
      len         <= '0;
      chans       <= '0;
      left        <= 1'b0;
      ana_channel <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (ev[0]) begin
            ana_cal_start <= 1'b1;
            state         <= ST_CAL;
          end else if (ev[2]) begin
            len       <= link.seq_len;
            chans     <= link.seq_chan;
            left      <= link.align_left;
            idx       <= '0;
            ana_start <= 1'b1;
            state     <= ST_CONV;
            ana_channel <= (link.seq_chan[CHANNEL_WIDTH-1:0] > CHANNEL_LAST)
                         ? '0 : link.seq_chan[CHANNEL_WIDTH-1:0];
          end
        end
        ST_CAL: begin
          if (ana_done) begin
            state <= ST_IDLE;
          end
        end
        ST_CONV: begin
          if (ana_done && idx == len) begin
            state <= ST_IDLE;
          end else if (ana_done) begin
            idx       <= idx + 1'b1;
            ana_start <= 1'b1;
          end
          if (ana_done && idx != len) begin
            ana_channel <= (next_channel > CHANNEL_LAST)
                         ? '0 : next_channel;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Calibration factor and results.
  // ************************************************************
  // The factor lives until power-off, which resets this domain, or until a calibration reset.
  always_ff @(posedge conv_clk) begin
    if (conv_rst || ev[1]) begin
      factor <= '0;
    end else if (state == ST_CAL && ana_done) begin
      factor <= ana_result;
    end
  end

  assign corrected = (ana_result > factor) ? ana_result - factor : '0;

  // Toggles reset only with the system, so power-off makes no event.
  always_ff @(posedge conv_clk) begin
    if (rst_s2) begin
      link.cal_done_tgl  <= 1'b0;
      link.conv_done_tgl <= 1'b0;
      link.result        <= '0;
    end else if (!conv_rst && ana_done) begin
      if (state == ST_CAL) begin
        link.cal_done_tgl <= ~link.cal_done_tgl;
      end
      if (state == ST_CONV && idx == len) begin
        link.result <= left ? {corrected, 4'h0}
                            : {4'h0, corrected};
        link.conv_done_tgl <= ~link.conv_done_tgl;
      end
    end
  end

  power_down_a: assert property (@(posedge conv_clk)
    (rst_s2 | ~on_s2) |=> ana_power_down)
    else $error("Analog core not powered down while off.");
  off_idle_a: assert property (@(posedge conv_clk) disable iff (rst_s2)
    conv_rst |=> state == ST_IDLE)
    else $error("Sequencer active while converter off.");
  cal_reset_a: assert property (@(posedge conv_clk)
    disable iff (conv_rst) ev[1] |=> factor == '0 && ana_cal_reset)
    else $error("Calibration reset did not clear factor.");
endmodule

// ==== ana_core_model.sv ====
// Behavioural model of the analog converter core and input multiplexer.
`timescale 1ns/1ps
module ana_core_model #(
  parameter logic [11:0] CAL_CODE  = 12'h005,
  parameter int          CAL_WAIT  = 8,
  parameter int          CONV_WAIT = 2
) (
  input  wire logic       clk,
  input  wire logic       power_down,
  input  wire logic       cal_start,
  input  wire logic       start,
  input  wire logic [4:0] channel,
  output logic            done,
  output logic [11:0]     result
);
  // ****************************************************
  // Answer logic.
  // ****************************************************
  int          wait_left = 0;
  logic [11:0] held      = 12'h000;
  initial done = 1'b0;
  initial result = 12'h000;
  // Result is true only with done; it flips otherwise so no stale match.
  always @(posedge clk) begin
    done <= 1'b0;
    result <= ~result;
    if (power_down) begin
      wait_left <= 0;
    end else if (cal_start) begin
      wait_left <= CAL_WAIT;
      held <= CAL_CODE;
    end else if (start) begin
      wait_left <= CONV_WAIT;
      held <= {channel, 7'h08};
    end else if (wait_left == 1) begin
      wait_left <= 0;
      done <= 1'b1;
      result <= held;
    end else if (wait_left > 1) begin
      wait_left <= wait_left - 1;
    end
  end
endmodule

// ==== adc_seq_ctrl_tb.sv ====
// Self-checking bench of the converter control block over APB.
`timescale 1ns/1ps
module adc_seq_ctrl_tb;
  import adc_ctrl_pkg::*;
  // ****************************************************
  // Clocks, drive and observers.
  // ****************************************************
  localparam logic [11:0] CAL = 12'h005;
  localparam logic [11:0] RAW = {5'h12, 7'h08};
  logic        CORE_CLK = 0, CONV_CLK = 0, RST = 1, err;
  logic        PSEL = 0, PENABLE = 0, PWRITE = 0, saw_rst = 0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA, q;
  logic        PREADY, PSLVERR, IRQ, ANA_DONE, ANA_POWER_DOWN;
  logic        ANA_CAL_START, ANA_CAL_RESET, ANA_START;
  logic [11:0] ANA_RESULT;
  logic [4:0]  ANA_CHANNEL;
  logic [4:0]  chans[$];
  int          bad_count = 0, n_checks = 0;
  // The converter clock is unrelated in phase and rate to the bus clock.
  always #5 CORE_CLK = ~CORE_CLK;
  always #7.3 CONV_CLK = ~CONV_CLK;
  adc_seq_ctrl i_dut (.CORE_CLK, .RST, .CONV_CLK, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .IRQ,
    .ANA_DONE, .ANA_RESULT, .ANA_POWER_DOWN, .ANA_CAL_START,
    .ANA_CAL_RESET, .ANA_START, .ANA_CHANNEL);
  ana_core_model #(.CAL_CODE(CAL)) i_model (.clk(CONV_CLK),
    .power_down(ANA_POWER_DOWN), .cal_start(ANA_CAL_START),
    .start(ANA_START), .channel(ANA_CHANNEL), .done(ANA_DONE),
    .result(ANA_RESULT));
  // Record every channel sent and flag any calibration reset pulse.
  always @(posedge CONV_CLK) begin
    if (ANA_START === 1'b1) chans.push_back(ANA_CHANNEL);
    if (ANA_CAL_RESET === 1'b1) saw_rst <= 1'b1;
  end
  task automatic chk(input logic [31:0] seen, exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One APB transfer; the request stands until PREADY is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
    if (n >= 20) chk(1'b0, 1'b1, "apb ready");
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0000_0000);
      n++;
    end while (q[b] !== v && n < 100);
    chk(q[b], v, "poll");
  endtask
  // Run the two-slot sequence, then read and check the result and clear its done flag.
  task automatic conv(input logic [31:0] ctl, input logic [15:0] exp,
                      input logic irq);
    chans.delete();
    apb(1'b1, CONTROL_SECOND_OFF, ctl);
    poll(STATUS_OFFSET, FLAG_CONV_DONE, 1'b1);
    repeat (2) @(posedge CONV_CLK);
    @(posedge CORE_CLK);
    chk(IRQ, irq, "irq");
    apb(1'b0, DATA_OFFSET, 32'h0000_0000);
    chk(q[15:0], exp, "data");
    chk(chans.size(), 2, "slots");
    chk({chans[0], chans[1]}, {5'h03, 5'h12}, "channels");
    apb(1'b1, STATUS_OFFSET, 32'h0000_0001);
    repeat (2) @(posedge CORE_CLK);
    chk(IRQ, 1'b0, "irq clear");
  endtask
  initial begin
    #100000;
    bad_count++;
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    apb(1'b0, CONTROL_SECOND_OFF, 32'h0000_0000);
    chk(q, REG_RESET, "control reset");
    chk(ANA_POWER_DOWN, 1'b1, "power down");
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(err, 1'b1, "unmapped");
    chk(q, 32'h0000_0000, "unmapped data");
    apb(1'b1, CONTROL_SECOND_OFF, 32'h0000_0001);
    repeat (14) @(posedge CONV_CLK);
    @(posedge CORE_CLK);
    chk(ANA_POWER_DOWN, 1'b0, "power up");
    apb(1'b1, CONTROL_SECOND_OFF, 32'h0000_000d);
    apb(1'b0, CONTROL_SECOND_OFF, 32'h0000_0000);
    chk(q[CTL_CAL_START_BIT], 1'b1, "cal running");
    poll(CONTROL_SECOND_OFF, CTL_CAL_START_BIT, 1'b0);
    chk(q[CTL_CAL_START_BIT], 1'b0, "cal cleared");
    chk(saw_rst, 1'b1, "cal reset");
    apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
    chk(q[FLAG_CAL_DONE], 1'b1, "cal done");
    apb(1'b1, MASK_OFFSET, 32'h0000_0001);
    apb(1'b1, SEQ_THIRD_OFFSET, 32'h0000_0243);
    apb(1'b1, SEQ_FIRST_OFFSET, 32'h0010_0000);
    conv(32'h0040_0001, {4'h0, RAW - CAL}, 1'b1);
    conv(32'h0040_0801, {RAW - CAL, 4'h0}, 1'b1);
    apb(1'b1, CONTROL_SECOND_OFF, 32'h0000_0000);
    apb(1'b1, MASK_OFFSET, 32'h0000_0000);
    apb(1'b1, CONTROL_SECOND_OFF, 32'h0000_0001);
    repeat (14) @(posedge CONV_CLK);
    @(posedge CORE_CLK);
    conv(32'h0040_0001, {4'h0, RAW}, 1'b0);
    apb(1'b1, CONTROL_SECOND_OFF, 32'h0000_0005);
    poll(CONTROL_SECOND_OFF, CTL_CAL_START_BIT, 1'b0);
    conv(32'h0040_0001, {4'h0, RAW - CAL}, 1'b0);
    end_of_test;
  end
endmodule
